// [adw_top.sv]
// Purpose: writes converter results into a RAM ring or linear buffer
// Assumes: zero-wait AHB-Lite slave, RAM port with ready handshake
// Notes: one RAM write outstanding; a result arriving while busy is dropped
`timescale 1ns/1ps
module adw_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  output logic ram_we,
  output logic [31:0] ram_addr,
  output logic [15:0] ram_wdata,
  input wire logic ram_ready,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // bus slave
  logic [15:0] addr_ff;
  logic wr_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic ahb_go;
  logic wr_now;
  logic [31:0] rd_mux;

  function automatic logic wr_hit(input logic [15:0] a, input logic [15:0] o);
    return a == o;
  endfunction

  assign ahb_go = hsel & htrans[1] & hready;
  assign wr_now = wr_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_ff <= 16'h0000;
      wr_ff <= 1'b0;
      hreadyout_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
    end
    else
    begin
      addr_ff <= haddr;
      wr_ff <= ahb_go & hwrite;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= (ahb_go & ~hwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register decode
  logic [12:0] start_ff;
  logic [12:0] cap_ff;
  logic [12:0] next_ff;
  logic [12:0] cnt_ff;
  logic wrap_ff;
  logic ovf_ff;
  logic [4:0] pend_ff;
  logic [4:0] en_ff;
  logic irq_ff;
  adw_pkg::adw_state_e state_ff;
  logic w_pend;
  logic w_en;
  logic w_ctrl;
  logic w_start;
  logic w_cap;
  logic eng_rst;
  logic arm_set;

  assign w_pend = wr_now & wr_hit(addr_ff, adw_pkg::OFS_PEND);
  assign w_en = wr_now & wr_hit(addr_ff, adw_pkg::OFS_EN);
  assign w_ctrl = wr_now & wr_hit(addr_ff, adw_pkg::OFS_CTRL);
  assign w_start = wr_now & wr_hit(addr_ff, adw_pkg::OFS_START);
  assign w_cap = wr_now & wr_hit(addr_ff, adw_pkg::OFS_CAP);
  assign eng_rst = w_ctrl & hwdata[adw_pkg::CTRL_RST_BIT]; // [R14]
  assign arm_set = w_ctrl & hwdata[adw_pkg::CTRL_ARM_BIT]; // [R13]

  assign rd_mux =
    wr_hit(haddr, adw_pkg::OFS_PEND) ? {27'h0, pend_ff} :
    wr_hit(haddr, adw_pkg::OFS_EN) ? {27'h0, en_ff} :
    wr_hit(haddr, adw_pkg::OFS_CTRL) ?
      {30'h0, wrap_ff, state_ff == adw_pkg::ST_ARMED} :
    wr_hit(haddr, adw_pkg::OFS_STAT) ?
      {30'h0, ovf_ff, state_ff == adw_pkg::ST_RUN} : // [R3] [R9]
    wr_hit(haddr, adw_pkg::OFS_START) ? (adw_pkg::RAM_BASE | {19'h0, start_ff}) : // [R8]
    wr_hit(haddr, adw_pkg::OFS_CAP) ? {19'h0, cap_ff} : // [R10]
    wr_hit(haddr, adw_pkg::OFS_NEXT) ? (adw_pkg::RAM_BASE | {18'h0, next_ff, 1'b0}) : // [R6]
    wr_hit(haddr, adw_pkg::OFS_CNT) ? {19'h0, cnt_ff} : // [R7]
    32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      start_ff <= adw_pkg::FIELD_RST;
      cap_ff <= adw_pkg::FIELD_RST;
      wrap_ff <= 1'b0;
      en_ff <= adw_pkg::IRQ_RST;
    end
    else
    begin
      if (w_start)
        start_ff <= hwdata[12:0]; // [R4]
      if (w_cap)
        cap_ff <= hwdata[12:0]; // [R5]
      if (w_ctrl)
        wrap_ff <= hwdata[adw_pkg::CTRL_WRAP_BIT];
      if (w_en)
        en_ff <= hwdata[4:0] & adw_pkg::IRQ_MASK; // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer engine
  logic running;
  logic acc;
  logic ovf_evt;
  logic last;
  logic half;
  logic [12:0] cnt_inc;
  logic [12:0] nxt_next;
  logic [12:0] nxt_cnt;
  adw_pkg::adw_state_e nxt_state;
  logic [4:0] pend_set;

  assign running = state_ff == adw_pkg::ST_RUN;
  assign acc = running & result_valid & (~ram_we | ram_ready);
  assign ovf_evt = result_valid & ~acc; // [R1]
  assign cnt_inc = cnt_ff + 13'h0001;
  assign last = acc & (cnt_inc == cap_ff);
  assign half = acc & (cnt_inc == {1'b0, cap_ff[12:1]}) & (cap_ff[12:1] != 12'h000);

  assign nxt_next = eng_rst ? start_ff : // [R18]
    (last & wrap_ff) ? start_ff : // [R15]
    acc ? next_ff + 13'h0001 : next_ff; // [R17]
  assign nxt_cnt = (eng_rst | (last & wrap_ff)) ? 13'h0000 :
    acc ? cnt_inc : cnt_ff; // [R17] [R18]

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      adw_pkg::ST_IDLE:
        if (arm_set)
          nxt_state = adw_pkg::ST_ARMED; // [R13]
      adw_pkg::ST_ARMED:
        nxt_state = (cap_ff == 13'h0000) ? adw_pkg::ST_IDLE : adw_pkg::ST_RUN;
      adw_pkg::ST_RUN:
        if (last & ~wrap_ff)
          nxt_state = adw_pkg::ST_IDLE; // [R15]
      default:
        nxt_state = adw_pkg::ST_IDLE;
    endcase
    if (eng_rst)
      nxt_state = adw_pkg::ST_IDLE; // [R13] [R14]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= adw_pkg::ST_IDLE;
      next_ff <= adw_pkg::FIELD_RST;
      cnt_ff <= adw_pkg::FIELD_RST;
      ovf_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      next_ff <= nxt_next;
      cnt_ff <= nxt_cnt;
      if (eng_rst)
        ovf_ff <= 1'b0; // [R2]
      else if (ovf_evt)
        ovf_ff <= 1'b1; // [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ram write port, held until accepted
  logic ram_we_ff;
  logic [31:0] ram_addr_ff;
  logic [15:0] ram_wdata_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ram_we_ff <= 1'b0;
      ram_addr_ff <= 32'h0000_0000;
      ram_wdata_ff <= 16'h0000;
    end
    else if (acc)
    begin
      ram_we_ff <= 1'b1;
      ram_addr_ff <= adw_pkg::RAM_BASE | {18'h0, next_ff, 1'b0}; // [R17]
      ram_wdata_ff <= result_data;
    end
    else if (ram_ready)
      ram_we_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt pending, write one to clear, set wins
  assign pend_set = {ovf_evt, 1'b0, last, half, 1'b0}; // [R16]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_ff <= adw_pkg::IRQ_RST;
      irq_ff <= 1'b0;
    end
    else
    begin
      pend_ff <= (pend_ff & ~(w_pend ? hwdata[4:0] : 5'h00)) | pend_set;
      irq_ff <= |(pend_ff & en_ff); // [R16]
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;
  assign ram_we = ram_we_ff;
  assign ram_addr = ram_addr_ff;
  assign ram_wdata = ram_wdata_ff;
  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_arm_idle;
    arm_set && !eng_rst && state_ff == adw_pkg::ST_IDLE && cap_ff != 13'h0000;
  endsequence
  sequence s_start;
    state_ff == adw_pkg::ST_ARMED ##1 state_ff == adw_pkg::ST_RUN;
  endsequence

  a_arm_starts: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    s_arm_idle ##1 !eng_rst |-> s_start)
    else $error("arm did not start engine");
  a_ovf_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
    result_valid && !running && !eng_rst |=> ovf_ff && pend_ff[adw_pkg::IRQ_OVF_BIT])
    else $error("overrun not flagged");
  a_ovf_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
    ovf_ff && !eng_rst |=> ovf_ff)
    else $error("overrun cleared without engine reset");
  a_rst_reload: assert property (@(posedge hclk) disable iff (!hresetn) // [R18]
    eng_rst |=> next_ff == $past(start_ff) && cnt_ff == 13'h0000 && !ovf_ff
      && state_ff == adw_pkg::ST_IDLE)
    else $error("engine reset did not reload");
  a_store_adv: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
    acc && !last && !eng_rst |=> next_ff == $past(next_ff) + 13'h0001
      && cnt_ff == $past(cnt_inc) && ram_we && ram_wdata == $past(result_data))
    else $error("store did not advance");
  a_linear_stop: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
    last && !wrap_ff && !eng_rst |=> state_ff == adw_pkg::ST_IDLE
      && pend_ff[adw_pkg::IRQ_FULL_BIT])
    else $error("linear buffer did not stop");
  a_wrap_back: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
    last && wrap_ff && !eng_rst |=> running && next_ff == $past(start_ff)
      && cnt_ff == 13'h0000)
    else $error("wrap did not return to start");
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    (pend_ff & en_ff) != 5'h00 |=> irq)
    else $error("enabled pending flag without interrupt");
  a_act_read: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
    ahb_go && !hwrite && haddr == adw_pkg::OFS_STAT
      |=> hrdata[adw_pkg::STAT_ACT_BIT] == $past(running))
    else $error("active flag misread");
  a_irq_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    (pend_ff & en_ff) == 5'h00 |=> !irq)
    else $error("interrupt without enabled pending flag");
  a_pend_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    w_pend && hwdata[adw_pkg::IRQ_FULL_BIT] && !last |=> !pend_ff[adw_pkg::IRQ_FULL_BIT])
    else $error("full pending not cleared by write one");
  a_half_flag: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    half |=> pend_ff[adw_pkg::IRQ_HALF_BIT])
    else $error("half full pending not raised");
  a_en_write: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    w_en |=> en_ff == ($past(hwdata[4:0]) & adw_pkg::IRQ_MASK))
    else $error("enable register write lost");
  a_start_write: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
    w_start |=> start_ff == $past(hwdata[12:0]))
    else $error("start field write lost");
  a_cap_write: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
    w_cap |=> cap_ff == $past(hwdata[12:0]))
    else $error("capacity field write lost");
  a_ram_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
    ram_we && !ram_ready |=> ram_we && $stable(ram_addr) && $stable(ram_wdata))
    else $error("ram write dropped before accept");
  a_addr_track: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
    acc |=> ram_addr == (adw_pkg::RAM_BASE | {18'h0, $past(next_ff), 1'b0}))
    else $error("ram address not next location");
  a_cap_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    state_ff == adw_pkg::ST_ARMED && cap_ff == 13'h0000 && !eng_rst
      |=> state_ff == adw_pkg::ST_IDLE)
    else $error("empty buffer started engine");
endmodule // adw_top

// [adw_pkg.sv]
// Purpose: constants for the converter result buffer writer
// Assumes: 32-bit AHB-Lite register access, 16-bit results
// Notes: offsets are byte addresses within the block
// Operation
// R1: result while engine idle sets overrun
// R2: overrun cleared only by engine reset
// R3: active flag reads engine running state
// R4: 13-bit start address field, read/write
// R5: capacity counts 16-bit results, not bytes
// R6: next-address field at bits 13:1
// R7: written-count field reports stored results
// R8: start and next registers reset 0x20000000
// R9: status register resets to zero
// R10: capacity and count registers reset zero
// R11: software keeps start reserved bits zero
// R12: software keeps status reserved bits zero
// R13: arm bit starts engine, self-clears
// R14: engine reset bit resets, self-clears
// R15: linear mode stops, wrap mode restarts
// R16: half, full, overflow pending with enables
// R17: store result, advance address and count
// R18: engine reset reloads address, clears count
package adw_pkg;
  localparam logic [15:0] OFS_PEND = 16'hA810;
  localparam logic [15:0] OFS_EN = 16'hA850;
  localparam logic [15:0] OFS_CTRL = 16'hD010;
  localparam logic [15:0] OFS_STAT = 16'hD014;
  localparam logic [15:0] OFS_START = 16'hD018;
  localparam logic [15:0] OFS_CAP = 16'hD01C;
  localparam logic [15:0] OFS_NEXT = 16'hD020;
  localparam logic [15:0] OFS_CNT = 16'hD024;
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_WRAP_BIT = 1;
  localparam int CTRL_RST_BIT = 4;
  localparam int STAT_ACT_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam int IRQ_HALF_BIT = 1;
  localparam int IRQ_FULL_BIT = 2;
  localparam int IRQ_OVF_BIT = 4;
  localparam logic [4:0] IRQ_MASK = 5'h16;
  localparam logic [31:0] RAM_BASE = 32'h2000_0000;
  localparam logic [12:0] FIELD_RST = 13'h0000;
  localparam logic [4:0] IRQ_RST = 5'h00;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN = 2'b10
  } adw_state_e;
endpackage

// [adw_ram_model.sv]
// Purpose: system RAM partner for the result writer
// Assumes: a write is taken on an edge with we and ready high
// Notes: slow mode toggles ready every cycle to stall writes
`timescale 1ns/1ps
module adw_ram_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [15:0] wdata,
  input wire logic slow,
  output logic ready,
  output logic [31:0] seen_addr_ff,
  output logic [15:0] seen_data_ff,
  output logic [7:0] wr_cnt_ff
);
  logic tog_ff;
  assign ready = slow ? tog_ff : 1'b1;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tog_ff <= 1'b0;
      wr_cnt_ff <= 8'h00;
      seen_addr_ff <= 32'h0;
      seen_data_ff <= 16'h0;
    end
    else
    begin
      tog_ff <= ~tog_ff;
      if (we && ready)
      begin
        wr_cnt_ff <= wr_cnt_ff + 8'h01;
        seen_addr_ff <= addr;
        seen_data_ff <= wdata;
      end
    end
  end
endmodule // adw_ram_model

// [adw_top_test.sv]
// Purpose: self-checking bench for the result buffer writer
// Assumes: zero-wait register slave, RAM partner model
// Notes: linear and overrun runs, then a wrap run with a stalling RAM
`timescale 1ns/1ps
module adw_top_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [15:0] haddr = 16'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic result_valid = 1'b0;
  logic [15:0] result_data = 16'h0;
  logic slow = 1'b0;
  logic hreadyout, hresp, ram_we, ram_ready, irq;
  logic [31:0] hrdata, ram_addr, seen_addr;
  logic [15:0] ram_wdata, seen_data;
  logic [7:0] wr_cnt;
  int error_cnt = 0;
  int cmp_count = 0;
  localparam logic [31:0] B = 32'h2000_0000;
  always #4 hclk = ~hclk;
  adw_top u_adw_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .result_valid(result_valid),
    .result_data(result_data), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_ready(ram_ready), .irq(irq));
  adw_ram_model u_adw_ram_model (.clk(hclk), .rst_n(hresetn), .we(ram_we), .addr(ram_addr),
    .wdata(ram_wdata), .slow(slow), .ready(ram_ready), .seen_addr_ff(seen_addr),
    .seen_data_ff(seen_data), .wr_cnt_ff(wr_cnt));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // one-cycle result pulse, then wait out the RAM write
  task automatic res(input logic [15:0] d);
    @(posedge hclk);
    result_valid <= 1'b1;
    result_data <= d;
    @(posedge hclk);
    result_valid <= 1'b0;
    #1;
    for (int n = 0; n < 20 && ram_we === 1'b1; n++)
      @(posedge hclk) #1;
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge hclk);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(adw_pkg::OFS_STAT, 32'h0);
    rd(adw_pkg::OFS_START, B);
    rd(adw_pkg::OFS_NEXT, B);
    rd(adw_pkg::OFS_CAP, 32'h0);
    rd(adw_pkg::OFS_CNT, 32'h0);
    wr(16'hA814, 32'hFFFF_FFFF);
    rd(16'hA814, 32'h0);
    wr(adw_pkg::OFS_CTRL, 32'h1);
    repeat (2) @(posedge hclk);
    rd(adw_pkg::OFS_STAT, 32'h0);
  endtask
  task automatic t_linear();
    wr(adw_pkg::OFS_EN, 32'h16);
    wr(adw_pkg::OFS_START, 32'h10);
    wr(adw_pkg::OFS_CAP, 32'h4);
    wr(adw_pkg::OFS_CTRL, 32'h10);
    wr(adw_pkg::OFS_CTRL, 32'h1);
    repeat (2) @(posedge hclk);
    rd(adw_pkg::OFS_STAT, 32'h1);
    rd(adw_pkg::OFS_START, B | 32'h10);
    rd(adw_pkg::OFS_CAP, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      res(16'hA500 + i[15:0]);
      chk(seen_addr, B + 32'h20 + 32'(2 * i));
      chk({16'h0, seen_data}, 32'hA500 + 32'(i));
    end
    rd(adw_pkg::OFS_NEXT, B | 32'h28);
    rd(adw_pkg::OFS_CNT, 32'h4);
    rd(adw_pkg::OFS_STAT, 32'h0);
    rd(adw_pkg::OFS_PEND, 32'h6);
    irq_is(1'b1);
    wr(adw_pkg::OFS_PEND, 32'h6);
    irq_is(1'b0);
  endtask
  task automatic t_overrun();
    res(16'h1234);
    chk({24'h0, wr_cnt}, 32'h4);
    rd(adw_pkg::OFS_STAT, 32'h2);
    rd(adw_pkg::OFS_PEND, 32'h10);
    irq_is(1'b1);
    wr(adw_pkg::OFS_EN, 32'h0);
    irq_is(1'b0);
    wr(adw_pkg::OFS_STAT, 32'h0);
    rd(adw_pkg::OFS_STAT, 32'h2);
    wr(adw_pkg::OFS_PEND, 32'h10);
  endtask
  task automatic t_wrap();
    slow <= 1'b1;
    wr(adw_pkg::OFS_START, 32'h20);
    wr(adw_pkg::OFS_CAP, 32'h2);
    wr(adw_pkg::OFS_CTRL, 32'h12);
    wr(adw_pkg::OFS_CTRL, 32'h3);
    repeat (2) @(posedge hclk);
    rd(adw_pkg::OFS_CTRL, 32'h2);
    for (int i = 0; i < 3; i++)
    begin
      res(16'h0F00 + i[15:0]);
      chk(seen_addr, B + 32'h40 + 32'(2 * (i % 2)));
    end
    rd(adw_pkg::OFS_NEXT, B | 32'h42);
    rd(adw_pkg::OFS_CNT, 32'h1);
    rd(adw_pkg::OFS_STAT, 32'h1);
    wr(adw_pkg::OFS_CTRL, 32'h12);
    rd(adw_pkg::OFS_STAT, 32'h0);
    rd(adw_pkg::OFS_CTRL, 32'h2);
    rd(adw_pkg::OFS_NEXT, B | 32'h40);
    rd(adw_pkg::OFS_CNT, 32'h0);
    res(16'h5A5A);
    rd(adw_pkg::OFS_STAT, 32'h2);
    wr(adw_pkg::OFS_CTRL, 32'h10);
    rd(adw_pkg::OFS_STAT, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_linear();
    t_overrun();
    t_wrap();
    test_done();
  end
  initial
  begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule // adw_top_test
